//--- hdl/upgs_pkg.sv
// Functional notes
// - Activity-gated flow gets periodic grants when active, periodic polls when inactive.
// - On grant restart add grants so modem gets one extra grant.
// - Header bit 7 is overrun flag; low seven bits are active grants.
// - Active grants count ignored for fixed flows, used for activity-gated flows.
// - Overrun extra grants obey rate limit, only in steady state.
// - Extra bytes capped at T*1.01*nominal rate plus three grant bursts.
// - Overrun flag set means arrivals exceed upstream rate; clear means none.
// - Background polling flows get unicast polls, about one second apart unless a poll interval is given.
// - Committed-rate service is opportunistic or background polling with nonzero minimum rate.
// - Rates and priority default 0, burst 3044; none apply to grant services.
// - Type and policy mandatory except opportunistic, defaulting to type 2, policy 0.
// - Grant parameters mandatory for grant services; poll interval defaults to grant interval.
// - Requests carrying a not-applicable parameter are rejected.
package upgs_pkg;

    // ------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [31:0] NRT_POLL_US = 32'd1000000;

    // ------------------------------------------------------------
    // Scheduling type codes
    // ------------------------------------------------------------
    localparam logic [7:0] ST_OPPORTUNISTIC = 8'h02;
    localparam logic [7:0] ST_BG_POLL       = 8'h03;
    localparam logic [7:0] ST_RT_POLL       = 8'h04;
    localparam logic [7:0] ST_GATED_GRANT   = 8'h05;
    localparam logic [7:0] ST_FIXED_GRANT   = 8'h06;

    // ------------------------------------------------------------
    // Parameter defaults
    // ------------------------------------------------------------
    localparam logic [7:0]  STYPE_DEFAULT  = ST_OPPORTUNISTIC;
    localparam logic [7:0]  POLICY_DEFAULT = 8'h00;
    localparam logic [2:0]  PRIO_DEFAULT   = 3'h0;
    localparam logic [31:0] SRATE_DEFAULT  = 32'h0;
    localparam logic [31:0] MRATE_DEFAULT  = 32'h0;
    localparam logic [31:0] BURST_DEFAULT  = 32'd3044;

    // ------------------------------------------------------------
    // Parameter presence bit positions
    // ------------------------------------------------------------
    localparam int P_PRIO    = 0;
    localparam int P_MCB     = 1;
    localparam int P_STYPE   = 2;
    localparam int P_POLICY  = 3;
    localparam int P_SRATE   = 4;
    localparam int P_BURST   = 5;
    localparam int P_MRATE   = 6;
    localparam int P_MINPKT  = 7;
    localparam int P_GSIZE   = 8;
    localparam int P_GPI     = 9;
    localparam int P_GINT    = 10;
    localparam int P_GJIT    = 11;
    localparam int P_PINT    = 12;
    localparam int P_PJIT    = 13;
    localparam int NPARAM    = 14;

    // ------------------------------------------------------------
    // Applicability masks per type
    // ------------------------------------------------------------
    localparam logic [13:0] NA_OPP    = 14'h3f00;
    localparam logic [13:0] NA_BG     = 14'h2f00;
    localparam logic [13:0] NA_RT     = 14'h0f01;
    localparam logic [13:0] NA_FIXED  = 14'h3073;
    localparam logic [13:0] NA_GATED  = 14'h0073;
    localparam logic [13:0] MD_OPP    = 14'h0000;
    localparam logic [13:0] MD_BG     = 14'h000c;
    localparam logic [13:0] MD_RT     = 14'h100c;
    localparam logic [13:0] MD_GRANT  = 14'h0f0c;

    // ------------------------------------------------------------
    // Header layout and rate limit scaling
    // ------------------------------------------------------------
    localparam int HDR_FLAG_BIT = 7;
    localparam int RL_NOM_PCT   = 101;
    localparam int RL_SCALE     = 100;
    localparam int RL_BURST_MUL = 3;

    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_GRANT,
        MODE_POLL
    } upgs_mode_e;

endpackage

//--- hdl/upgs_rate_limit.sv
module upgs_rate_limit
    import upgs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Flow parameters
    input  wire logic        clear,
    input  wire logic [15:0] gsize,
    input  wire logic [6:0]  gpi,
    // Interval accounting
    input  wire logic        interval_stb,
    input  wire logic [7:0]  nominal,
    input  wire logic [7:0]  issued,
    output logic             extra_ok
);

    // Credit is kept in hundredths of a byte so the 1.01 factor stays exact
    logic [33:0] credit_reg;
    logic [33:0] burst_w;
    logic [33:0] add_w;
    logic [33:0] cap_w;
    logic [33:0] unit_w;
    logic [33:0] avail_w;
    logic [33:0] spend_w;
    logic [33:0] left_w;

    always_comb
    begin
        burst_w = 34'(gsize) * 34'(gpi);
        add_w   = burst_w * 34'(RL_NOM_PCT);
        cap_w   = burst_w * 34'(RL_SCALE * RL_BURST_MUL);
        unit_w  = 34'(gsize) * 34'(RL_SCALE);
        avail_w = credit_reg + add_w;
        spend_w = unit_w * 34'(issued);
        left_w  = (avail_w > spend_w) ? avail_w - spend_w : 34'h0;
        extra_ok = avail_w >= unit_w * (34'(nominal) + 34'h1);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            credit_reg <= 34'h0;
        else if (clear)
            credit_reg <= cap_w;
        else if (interval_stb)
            credit_reg <= (left_w > cap_w) ? cap_w : left_w;
    end

endmodule

//--- hdl/upgs_scheduler.sv
module upgs_scheduler
    import upgs_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        ARST_N,
    // Flow configuration request
    input  wire logic        CFG_STB,
    input  wire logic [13:0] CFG_PRESENT,
    input  wire logic [7:0]  CFG_STYPE,
    input  wire logic [7:0]  CFG_POLICY,
    input  wire logic [2:0]  CFG_PRIO,
    input  wire logic [31:0] CFG_SRATE,
    input  wire logic [31:0] CFG_BURST,
    input  wire logic [31:0] CFG_MRATE,
    input  wire logic [15:0] CFG_GSIZE,
    input  wire logic [6:0]  CFG_GPI,
    input  wire logic [31:0] CFG_GINT_US,
    input  wire logic [31:0] CFG_PINT_US,
    input  wire logic [7:0]  CFG_IDLE_LIMIT,
    // Configuration answer
    output logic             CFG_ACCEPT,
    output logic             CFG_REJECT,
    // Active flow parameters
    output logic [7:0]       ACT_STYPE,
    output logic [7:0]       ACT_POLICY,
    output logic [2:0]       ACT_PRIO,
    output logic [31:0]      ACT_SRATE,
    output logic [31:0]      ACT_BURST,
    output logic [31:0]      ACT_MRATE,
    output logic             CIR_MODE,
    // Upstream events from the burst receiver
    input  wire logic        HDR_STB,
    input  wire logic [7:0]  HDR_BYTE,
    input  wire logic        GRANT_USED,
    input  wire logic        GRANT_UNUSED,
    input  wire logic        REQ_STB,
    // Schedule output
    output logic             GRANT_STB,
    output logic [7:0]       GRANT_NUM,
    output logic             POLL_STB,
    output logic             FLOW_ACTIVE,
    output logic             OVERRUN_SEEN
);

    // ------------------------------------------------------------
    // Microsecond tick divider
    // ------------------------------------------------------------
    logic [4:0]  div_reg;
    logic        us_tick_reg;

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            div_reg     <= 5'h00;
            us_tick_reg <= 1'b0;
        end
        else
        begin
            us_tick_reg <= (div_reg == 5'(TICK_CYCLES - 1));
            div_reg     <= (div_reg == 5'(TICK_CYCLES - 1)) ? 5'h00 : div_reg + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // Configuration check
    // ------------------------------------------------------------
    logic [7:0]  stype_w;
    logic [13:0] na_w;
    logic [13:0] md_w;
    logic        known_w;
    logic        cfg_ok;
    logic        cfg_bad;

    always_comb
    begin
        stype_w = CFG_PRESENT[P_STYPE] ? CFG_STYPE : STYPE_DEFAULT;
        known_w = 1'b1;
        na_w    = NA_OPP;
        md_w    = MD_OPP;
        if (stype_w == ST_OPPORTUNISTIC)
        begin
            na_w = NA_OPP;
            md_w = MD_OPP;
        end
        else if (stype_w == ST_BG_POLL)
        begin
            na_w = NA_BG;
            md_w = MD_BG;
        end
        else if (stype_w == ST_RT_POLL)
        begin
            na_w = NA_RT;
            md_w = MD_RT;
        end
        else if (stype_w == ST_FIXED_GRANT)
        begin
            na_w = NA_FIXED;
            md_w = MD_GRANT;
        end
        else if (stype_w == ST_GATED_GRANT)
        begin
            na_w = NA_GATED;
            md_w = MD_GRANT;
        end
        else
            known_w = 1'b0;
        cfg_bad = !known_w || ((CFG_PRESENT & na_w) != 14'h0)
                  || ((CFG_PRESENT & md_w) != md_w);
        cfg_ok  = CFG_STB && !cfg_bad;
    end

    // ------------------------------------------------------------
    // Active parameter set
    // ------------------------------------------------------------
    logic [15:0] gsize_reg;
    logic [6:0]  gpi_reg;
    logic [31:0] gint_reg;
    logic [31:0] pint_reg;
    logic [7:0]  idle_lim_reg;
    logic        gated;
    logic        fixed;

    assign gated = (ACT_STYPE == ST_GATED_GRANT);
    assign fixed = (ACT_STYPE == ST_FIXED_GRANT);

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ACT_STYPE    <= STYPE_DEFAULT;
            ACT_POLICY   <= POLICY_DEFAULT;
            ACT_PRIO     <= PRIO_DEFAULT;
            ACT_SRATE    <= SRATE_DEFAULT;
            ACT_BURST    <= BURST_DEFAULT;
            ACT_MRATE    <= MRATE_DEFAULT;
            CIR_MODE     <= 1'b0;
            gsize_reg    <= 16'h0000;
            gpi_reg      <= 7'h00;
            gint_reg     <= 32'h0;
            pint_reg     <= 32'h0;
            idle_lim_reg <= 8'h00;
        end
        else if (cfg_ok)
        begin
            ACT_STYPE    <= stype_w;
            ACT_POLICY   <= CFG_PRESENT[P_POLICY] ? CFG_POLICY : POLICY_DEFAULT;
            // Not-applicable fields were refused above, so absent means default
            ACT_PRIO     <= CFG_PRESENT[P_PRIO]  ? CFG_PRIO  : PRIO_DEFAULT;
            ACT_SRATE    <= CFG_PRESENT[P_SRATE] ? CFG_SRATE : SRATE_DEFAULT;
            ACT_MRATE    <= CFG_PRESENT[P_MRATE] ? CFG_MRATE : MRATE_DEFAULT;
            ACT_BURST    <= CFG_PRESENT[P_BURST] ? CFG_BURST : BURST_DEFAULT;
            CIR_MODE     <= ((stype_w == ST_OPPORTUNISTIC) || (stype_w == ST_BG_POLL))
                            && CFG_PRESENT[P_MRATE] && (CFG_MRATE != 32'h0);
            gsize_reg    <= CFG_GSIZE;
            gpi_reg      <= CFG_GPI;
            gint_reg     <= CFG_GINT_US;
            idle_lim_reg <= CFG_IDLE_LIMIT;
            if (CFG_PRESENT[P_PINT])
                pint_reg <= CFG_PINT_US;
            else if (stype_w == ST_GATED_GRANT)
                pint_reg <= CFG_GINT_US;
            else
                pint_reg <= NRT_POLL_US;
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            CFG_ACCEPT <= 1'b0;
            CFG_REJECT <= 1'b0;
        end
        else
        begin
            CFG_ACCEPT <= cfg_ok;
            CFG_REJECT <= CFG_STB && cfg_bad;
        end
    end

    // ------------------------------------------------------------
    // Grant versus poll mode
    // ------------------------------------------------------------
    upgs_mode_e  mode_reg;
    upgs_mode_e  mode_next;
    logic [7:0]  unused_reg;
    logic [6:0]  act_reg;
    logic [6:0]  req_reg;
    logic        comp_reg;
    logic        restart;
    logic        idle_hit;
    logic [6:0]  hdr_cnt;

    assign hdr_cnt  = HDR_BYTE[6:0];
    assign restart  = gated && (mode_reg == MODE_POLL) && REQ_STB;
    assign idle_hit = GRANT_UNUSED && !GRANT_USED
                      && (9'(unused_reg) + 9'h1 >= 9'(idle_lim_reg));

    always_comb
    begin
        mode_next = mode_reg;
        if (cfg_ok)
        begin
            if (stype_w == ST_FIXED_GRANT)
                mode_next = MODE_GRANT;
            else if (stype_w == ST_OPPORTUNISTIC)
                mode_next = MODE_IDLE;
            else
                mode_next = MODE_POLL;
        end
        else if (gated && (mode_reg == MODE_GRANT))
        begin
            // Only one of grants or polls is ever in force
            if (HDR_STB && (hdr_cnt == 7'h00))
                mode_next = MODE_POLL;
            else if (idle_hit)
                mode_next = MODE_POLL;
        end
        else if (restart)
            mode_next = MODE_GRANT;
    end

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            mode_reg <= MODE_IDLE;
        else
            mode_reg <= mode_next;
    end

    // A used grant resets the run even when an unused one lands alongside
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            unused_reg <= 8'h00;
        else if (mode_next != MODE_GRANT || GRANT_USED)
            unused_reg <= 8'h00;
        else if (GRANT_UNUSED && unused_reg != 8'hff)
            unused_reg <= unused_reg + 8'h01;
    end

    // ------------------------------------------------------------
    // Interval timer
    // ------------------------------------------------------------
    logic [31:0] iv_cnt_reg;
    logic [31:0] ival;
    logic        iv_hit;

    assign ival   = (mode_reg == MODE_GRANT) ? gint_reg : pint_reg;
    assign iv_hit = us_tick_reg && (mode_reg != MODE_IDLE)
                    && (33'(iv_cnt_reg) + 33'h1 >= 33'(ival));

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            iv_cnt_reg <= 32'h0;
        else if (mode_next != mode_reg || iv_hit)
            iv_cnt_reg <= 32'h0;
        else if (us_tick_reg)
            iv_cnt_reg <= iv_cnt_reg + 32'h1;
    end

    // ------------------------------------------------------------
    // Active grants and overrun tracking
    // ------------------------------------------------------------
    logic        steady;
    logic        rl_ok;
    logic        extra;
    logic [7:0]  nominal;
    logic [7:0]  total;

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            act_reg      <= 7'h00;
            req_reg      <= 7'h00;
            comp_reg     <= 1'b0;
            OVERRUN_SEEN <= 1'b0;
        end
        else if (cfg_ok)
        begin
            act_reg      <= CFG_GPI;
            req_reg      <= CFG_GPI;
            comp_reg     <= 1'b0;
            OVERRUN_SEEN <= 1'b0;
        end
        else
        begin
            if (HDR_STB && (fixed || gated))
                OVERRUN_SEEN <= HDR_BYTE[HDR_FLAG_BIT];
            if (restart)
            begin
                act_reg  <= 7'h01;
                req_reg  <= 7'h01;
                comp_reg <= 1'b1;
            end
            else
            begin
                if (HDR_STB && gated && hdr_cnt != 7'h00)
                    req_reg <= (hdr_cnt > gpi_reg) ? gpi_reg : hdr_cnt;
                if (iv_hit && mode_reg == MODE_GRANT)
                begin
                    comp_reg <= 1'b0;
                    if (gated)
                        act_reg <= req_reg;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Grant and poll issue
    // ------------------------------------------------------------
    assign steady  = (act_reg == req_reg);
    assign nominal = {1'b0, act_reg} + {7'h00, comp_reg};
    assign extra   = OVERRUN_SEEN && steady && rl_ok;
    assign total   = nominal + {7'h00, extra};

    upgs_rate_limit u_rate_limit (
        .clk          (CLOCK),
        .arst_n       (ARST_N),
        .clear        (cfg_ok || restart),
        .gsize        (gsize_reg),
        .gpi          (gpi_reg),
        .interval_stb (iv_hit && (mode_reg == MODE_GRANT)),
        .nominal      (nominal),
        .issued       (total),
        .extra_ok     (rl_ok)
    );

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            GRANT_STB   <= 1'b0;
            GRANT_NUM   <= 8'h00;
            POLL_STB    <= 1'b0;
            FLOW_ACTIVE <= 1'b0;
        end
        else
        begin
            GRANT_STB   <= iv_hit && (mode_reg == MODE_GRANT);
            POLL_STB    <= iv_hit && (mode_reg == MODE_POLL);
            FLOW_ACTIVE <= (mode_next == MODE_GRANT);
            if (iv_hit && mode_reg == MODE_GRANT)
                GRANT_NUM <= total;
        end
    end

endmodule

//--- tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, arst_n = 1'b0, cfg_stb = 1'b0, want = 1'b0, ovr = 1'b0;
    logic [13:0] present = 14'h0000;
    logic [7:0] stype = 8'h00, act_stype, act_policy, hdr_byte, grant_num;
    logic [31:0] val = 32'h0, act_srate, act_burst, act_mrate;
    logic [6:0] cnt = 7'h01;
    logic [2:0] act_prio;
    logic hdr_stb, used, unused, req_stb, acc, rej, guaranteed_rate_service, grant_stb, poll_stb, active, ovr_seen;
    int n_fail = 0;
    int num_checks = 0;

    always #20 clock = ~clock;

    upgs_scheduler uut (
        .CLOCK(clock), .ARST_N(arst_n), .CFG_STB(cfg_stb), .CFG_PRESENT(present),
        .CFG_STYPE(stype), .CFG_POLICY(val[7:0]), .CFG_PRIO(val[2:0]), .CFG_SRATE(val),
        .CFG_BURST(val), .CFG_MRATE(val), .CFG_GSIZE(16'h0064), .CFG_GPI(7'h02),
        .CFG_GINT_US(32'h4), .CFG_PINT_US(32'h3), .CFG_IDLE_LIMIT(8'h02),
        .CFG_ACCEPT(acc), .CFG_REJECT(rej), .ACT_STYPE(act_stype), .ACT_POLICY(act_policy),
        .ACT_PRIO(act_prio), .ACT_SRATE(act_srate), .ACT_BURST(act_burst),
        .ACT_MRATE(act_mrate), .CIR_MODE(guaranteed_rate_service), .HDR_STB(hdr_stb), .HDR_BYTE(hdr_byte),
        .GRANT_USED(used), .GRANT_UNUSED(unused), .REQ_STB(req_stb),
        .GRANT_STB(grant_stb), .GRANT_NUM(grant_num), .POLL_STB(poll_stb),
        .FLOW_ACTIVE(active), .OVERRUN_SEEN(ovr_seen)
    );

    upgs_modem_model modem (
        .clk(clock), .want(want), .ovr(ovr), .cnt(cnt), .grant_stb(grant_stb),
        .poll_stb(poll_stb), .hdr_stb(hdr_stb), .hdr_byte(hdr_byte), .used(used),
        .unused(unused), .req_stb(req_stb)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cfg(input logic [13:0] p, input logic [7:0] t, input logic ok);
        @(negedge clock);
        present = p;
        stype = t;
        val = 32'h5;
        cfg_stb = 1'b1;
        @(negedge clock);
        cfg_stb = 1'b0;
        chk(acc, ok);
        chk(rej, !ok);
    endtask

    // Strobes stand a full cycle, so the falling edge always sees them
    task automatic wait_ev(input logic poll);
        int i;
        for (i = 0; i < 600; i++)
        begin
            @(negedge clock);
            if (poll ? poll_stb : grant_stb)
                break;
        end
        chk(i < 600, 1'b1);
    endtask

    task automatic t_cfg;
        chk({act_stype, act_prio}, {8'h02, 3'h0});
        chk(act_burst, 32'h0000_0be4);
        cfg(14'h0000, 8'h07, 1'b1);
        chk({act_stype, act_policy, act_mrate[7:0]}, 24'h020000);
        chk(act_burst, 32'h0000_0be4);
        cfg(14'h0104, 8'h02, 1'b0);
        cfg(14'h000c, 8'h05, 1'b0);
        cfg(14'h1f0c, 8'h06, 1'b0);
        cfg(14'h107d, 8'h03, 1'b1);
        chk({guaranteed_rate_service, act_stype, act_prio, act_mrate[7:0], act_burst[7:0]}, 28'h81d0505);
        chk(act_srate, 32'h0000_0005);
        wait_ev(1'b1);
    endtask

    task automatic t_gated;
        cfg(14'h0f0c, 8'h05, 1'b1);
        wait_ev(1'b1);
        chk(active, 1'b0);
        want <= 1'b1;
        wait_ev(1'b0);
        chk({active, grant_num}, 9'h102);
        wait_ev(1'b0);
        chk(grant_num, 8'h01);
        cnt <= 7'h00;
        wait_ev(1'b0);
        repeat (3) @(negedge clock);
        chk(active, 1'b0);
        cnt <= 7'h02;
        wait_ev(1'b0);
        chk(grant_num, 8'h02);
        // The new count arrives after the grant tick that would apply it
        wait_ev(1'b0);
        chk(grant_num, 8'h01);
        wait_ev(1'b0);
        chk(grant_num, 8'h02);
        want <= 1'b0;
        wait_ev(1'b1);
        chk(active, 1'b0);
    endtask

    task automatic t_fixed;
        want <= 1'b1;
        cnt <= 7'h01;
        cfg(14'h0f0c, 8'h06, 1'b1);
        chk(active, 1'b1);
        wait_ev(1'b0);
        wait_ev(1'b0);
        chk({ovr_seen, grant_num}, 9'h002);
        ovr <= 1'b1;
        wait_ev(1'b0);
        repeat (2) @(negedge clock);
        chk(ovr_seen, 1'b1);
        wait_ev(1'b0);
        chk(grant_num, 8'h03);
        // Credit starts at 3B and gains 1.01B per interval, so six extras drain it
        repeat (6) wait_ev(1'b0);
        chk(grant_num, 8'h02);
    endtask

    task automatic complete_run;
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(negedge clock);
        arst_n = 1'b1;
        t_cfg();
        t_gated();
        t_fixed();
        complete_run();
    end

    // ----------------------------------------
    // Watchdog: the full run is near 2300 cycles
    // ----------------------------------------
    initial
    begin
        #400000;
        n_fail++;
        complete_run();
    end
endmodule

//--- tb/upgs_modem_model.sv
module upgs_modem_model
(
    // Clock
    input wire logic       clk,
    // Behaviour knobs
    input wire logic       want,
    input wire logic       ovr,
    input wire logic [6:0] cnt,
    // Schedule from the head end
    input wire logic       grant_stb,
    input wire logic       poll_stb,
    // Upstream events
    output logic           hdr_stb,
    output logic [7:0]     hdr_byte,
    output logic           used,
    output logic           unused,
    output logic           req_stb
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {hdr_stb, hdr_byte, used, unused, req_stb} = 12'h000;
    end
    // No contention or piggyback path exists: access is only by poll or grant
    always @(negedge clk)
    begin
        hdr_stb <= grant_stb && want;
        used <= grant_stb && want;
        unused <= grant_stb && !want;
        // Released byte toggles so a stale header is never mistaken for a new one
        hdr_byte <= (grant_stb && want) ? {ovr, cnt} : ~hdr_byte;
        req_stb <= poll_stb && want;
    end
endmodule

//--- tb/upgs_sched_monitor.sv
module upgs_sched_monitor
    import upgs_pkg::*;
(
    // Clock and reset
    input wire logic        CLOCK,
    input wire logic        ARST_N,
    // Configuration
    input wire logic        CFG_STB,
    input wire logic [13:0] CFG_PRESENT,
    input wire logic [7:0]  CFG_STYPE,
    input wire logic        CFG_ACCEPT,
    input wire logic        CFG_REJECT,
    input wire logic [7:0]  ACT_STYPE,
    input wire logic [31:0] ACT_BURST,
    // Schedule
    input wire logic        HDR_STB,
    input wire logic [7:0]  HDR_BYTE,
    input wire logic        REQ_STB,
    input wire logic        GRANT_STB,
    input wire logic        POLL_STB,
    input wire logic        FLOW_ACTIVE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!ARST_N);
    logic opp_na;
    logic gated;
    // Absent type falls back to opportunistic, so its N/A set applies
    assign opp_na = (!CFG_PRESENT[P_STYPE] || CFG_STYPE == ST_OPPORTUNISTIC)
                    && (|(CFG_PRESENT & NA_OPP));
    assign gated = ACT_STYPE == ST_GATED_GRANT;

    a_reset_defaults: assert property ($rose(ARST_N) |->
        ACT_STYPE == ST_OPPORTUNISTIC && ACT_BURST == BURST_DEFAULT) else $error("reset values");
    a_cfg_answer: assert property (CFG_STB |=> CFG_ACCEPT != CFG_REJECT)
        else $error("config not answered once");
    a_cfg_quiet: assert property (!CFG_STB |=> !CFG_ACCEPT && !CFG_REJECT)
        else $error("unrequested config answer");
    a_na_reject: assert property (CFG_STB && opp_na |=> CFG_REJECT)
        else $error("not applicable parameter accepted");
    a_one_mode: assert property (GRANT_STB |-> !POLL_STB)
        else $error("grant and poll together");
    a_fixed_no_poll: assert property ($stable(ACT_STYPE) && ACT_STYPE == ST_FIXED_GRANT
        |-> !POLL_STB) else $error("fixed flow polled");
    a_poll_inactive: assert property (POLL_STB && gated |-> !FLOW_ACTIVE)
        else $error("poll while active");
    a_restart_grant: assert property (gated && !FLOW_ACTIVE && REQ_STB && !CFG_STB
        |=> FLOW_ACTIVE) else $error("no restart on request");
    a_zero_idle: assert property (gated && FLOW_ACTIVE && HDR_STB && HDR_BYTE[6:0] == 7'h00
        && !CFG_STB |=> !FLOW_ACTIVE) else $error("zero count kept grants");
endmodule

bind upgs_scheduler upgs_sched_monitor u_mon (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .CFG_STB(CFG_STB), .CFG_PRESENT(CFG_PRESENT),
    .CFG_STYPE(CFG_STYPE), .CFG_ACCEPT(CFG_ACCEPT), .CFG_REJECT(CFG_REJECT),
    .ACT_STYPE(ACT_STYPE), .ACT_BURST(ACT_BURST), .HDR_STB(HDR_STB), .HDR_BYTE(HDR_BYTE),
    .REQ_STB(REQ_STB), .GRANT_STB(GRANT_STB), .POLL_STB(POLL_STB), .FLOW_ACTIVE(FLOW_ACTIVE)
);
